//--- tmc_mode_control.sv
/*
 * Timer counter with its first control register, reload buffering, compare flag
 * timing, sampling clock divider and an AXI4-Lite register slave.
 * Assumes one 40 MHz clock, an asynchronous active-low reset, and a slave-mode
 * update pulse and encoder-mode level coming from logic on the same clock.
 */
`timescale 1ns/1ps
`include "tmc_params.svh"

module tmc_mode_control #(
  parameter int CW = `TMC_CNT_WIDTH
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_slave_update,
  input wire logic i_encoder_mode,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_irq,
  output logic o_update_event,
  output logic o_update_request,
  output logic o_compare_hit,
  output logic o_sample_tick,
  output logic o_counter_run
);
  tmc_pkg::tmc_ctrl_s ctrl_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] reload_buf_q;
  logic [CW-1:0] reload_act_q;
  logic [CW-1:0] cmp_q;
  logic [`TMC_ST_WIDTH-1:0] stat_q;
  logic [`TMC_ST_WIDTH-1:0] mask_q;
  logic [1:0] div_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Byte lanes merged into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Last divider count for a divide code; the reserved code behaves as 4x.
  function automatic logic [1:0] div_last(input logic [1:0] code);
    case (code)
      2'b00: div_last = 2'h0;
      2'b01: div_last = 2'h1;
      default: div_last = 2'h3;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `TMC_OFS_CTRL) || (a == `TMC_OFS_MASK) || (a == `TMC_OFS_STAT) ||
             (a == `TMC_OFS_EVGEN) || (a == `TMC_OFS_COUNT) || (a == `TMC_OFS_RELOAD) ||
             (a == `TMC_OFS_CMP);
  endfunction

  logic wr_fire, rd_fire, wr_ctrl, wr_cnt, wr_reload, sw_update, running, dir_down;
  logic centre, wrap, update_src, update_ev, update_req, reinit, cmp_dir_ok, cmp_hit;
  logic [CW-1:0] reload_next;
  logic [15:0] ctrl_wr;

  assign wr_fire = aw_got_q && w_got_q && !o_bvalid;
  assign rd_fire = i_arvalid && o_arready;
  assign wr_ctrl = wr_fire && (awaddr_q == `TMC_OFS_CTRL);
  assign wr_cnt = wr_fire && (awaddr_q == `TMC_OFS_COUNT);
  assign wr_reload = wr_fire && (awaddr_q == `TMC_OFS_RELOAD);
  assign sw_update = wr_fire && (awaddr_q == `TMC_OFS_EVGEN) && wstrb_q[0] &&
                     wdata_q[`TMC_BIT_SWUPD];
  assign running = ctrl_q.counter_run_enable;
  assign dir_down = ctrl_q.count_direction;
  assign centre = ctrl_q.alignment_select != tmc_pkg::TMC_ALIGN_EDGE;
  assign wrap = running && (dir_down ? (cnt_q == '0) : (cnt_q == reload_act_q));
  assign update_src = wrap || sw_update || i_slave_update;
  assign update_ev = !ctrl_q.update_disable_bit && update_src;
  assign update_req = !ctrl_q.update_disable_bit &&
                      (ctrl_q.update_request_source_sel ? wrap : update_src);
  assign reinit = update_ev && (sw_update || i_slave_update);
  assign reload_next = (ctrl_q.reload_buffer_enable && update_ev) ? reload_buf_q : reload_act_q;

  always_comb begin
    case (ctrl_q.alignment_select)
      tmc_pkg::TMC_ALIGN_DOWN: cmp_dir_ok = dir_down;
      tmc_pkg::TMC_ALIGN_UP: cmp_dir_ok = !dir_down;
      default: cmp_dir_ok = 1'b1;
    endcase
  end
  assign cmp_hit = running && (cnt_q == cmp_q) && cmp_dir_ok;

  assign ctrl_wr = merge16(ctrl_q, wdata_q, wstrb_q) & `TMC_CTRL_WMASK;

  // Control register: software writes, one-shot stop and centre direction turns.
  // A software write to the run bit loses to a one-shot stop in the same cycle.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= `TMC_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wr;
        if (centre || i_encoder_mode) begin
          ctrl_q.count_direction <= ctrl_q.count_direction;
        end
      end
      if (centre && wrap) begin
        ctrl_q.count_direction <= !dir_down;
      end
      if (ctrl_q.one_shot_enable && update_ev) begin
        ctrl_q.counter_run_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else if (reinit) begin
      cnt_q <= dir_down ? reload_next : '0;
    end else if (wr_cnt) begin
      cnt_q <= wdata_q[CW-1:0];
    end else if (running) begin
      if (wrap && !centre) begin
        cnt_q <= dir_down ? reload_next : '0;
      end else if (wrap) begin
        cnt_q <= dir_down ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end else begin
        cnt_q <= dir_down ? cnt_q - 1'b1 : cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reload_buf_q <= `TMC_RELOAD_RESET;
      reload_act_q <= `TMC_RELOAD_RESET;
    end else begin
      if (wr_reload) begin
        reload_buf_q <= wdata_q[CW-1:0];
      end
      if (wr_reload && !ctrl_q.reload_buffer_enable) begin
        reload_act_q <= wdata_q[CW-1:0];
      end else begin
        reload_act_q <= reload_next;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_q <= '0;
      mask_q <= '0;
    end else if (wr_fire) begin
      if (awaddr_q == `TMC_OFS_CMP) begin
        cmp_q <= wdata_q[CW-1:0];
      end
      if (awaddr_q == `TMC_OFS_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[`TMC_ST_WIDTH-1:0];
      end
    end
  end

  // Sticky status: a new event in the clearing cycle survives the clear.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < `TMC_ST_WIDTH; i++) begin
        if (wr_fire && awaddr_q == `TMC_OFS_STAT && wstrb_q[0] && wdata_q[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (update_req) begin
        stat_q[`TMC_ST_UPDATE] <= 1'b1;
      end
      if (cmp_hit) begin
        stat_q[`TMC_ST_COMPARE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q <= 2'h0;
      o_sample_tick <= 1'b0;
    end else if (div_q >= div_last(ctrl_q.sampling_clock_divide)) begin
      div_q <= 2'h0;
      o_sample_tick <= 1'b1;
    end else begin
      div_q <= div_q + 2'h1;
      o_sample_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
      o_update_event <= 1'b0;
      o_update_request <= 1'b0;
      o_compare_hit <= 1'b0;
      o_counter_run <= 1'b0;
    end else begin
      o_irq <= |(stat_q & mask_q);
      o_update_event <= update_ev;
      o_update_request <= update_req;
      o_compare_hit <= cmp_hit;
      o_counter_run <= running;
    end
  end

  // Write channels are taken in either order; the response waits for both.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got_q <= 1'b1;
        o_awready <= 1'b0;
        awaddr_q <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_got_q <= 1'b1;
        o_wready <= 1'b0;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= mapped(awaddr_q) ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
    end else if (rd_fire) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= mapped({i_araddr[7:2], 2'b00}) ? 2'h0 : 2'h2;
      case ({i_araddr[7:2], 2'b00})
        `TMC_OFS_CTRL: o_rdata <= {16'h0000, ctrl_q};
        `TMC_OFS_MASK: o_rdata <= {{(32-`TMC_ST_WIDTH){1'b0}}, mask_q};
        `TMC_OFS_STAT: o_rdata <= {{(32-`TMC_ST_WIDTH){1'b0}}, stat_q};
        `TMC_OFS_COUNT: o_rdata <= {{(32-CW){1'b0}}, cnt_q};
        `TMC_OFS_RELOAD: o_rdata <= {{(32-CW){1'b0}}, reload_buf_q};
        `TMC_OFS_CMP: o_rdata <= {{(32-CW){1'b0}}, cmp_q};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_oneshot_stop: assert property (
    ctrl_q.one_shot_enable && update_ev |=> !ctrl_q.counter_run_enable)
    else $error("one-shot did not stop counter");
  a_disable_blocks: assert property (
    ctrl_q.update_disable_bit |=> !o_update_event)
    else $error("update event while disabled");
  a_ovf_only_req: assert property (
    ctrl_q.update_request_source_sel && !wrap |=> !o_update_request)
    else $error("request from non-overflow source");
  a_sw_req: assert property (
    !ctrl_q.update_request_source_sel && !ctrl_q.update_disable_bit && sw_update
    |=> o_update_request ##1 stat_q[`TMC_ST_UPDATE])
    else $error("software update gave no request");
  a_dir_locked: assert property (
    centre && !wrap && wr_ctrl |=> $stable(ctrl_q.count_direction))
    else $error("direction written in centre mode");
  a_edge_up_count: assert property (
    running && !centre && !dir_down && !wrap && !wr_fire && !i_slave_update
    |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("edge up count wrong");
  a_centre_turn: assert property (
    centre && wrap && !ctrl_q.one_shot_enable && !wr_fire
    |=> ctrl_q.count_direction != $past(ctrl_q.count_direction))
    else $error("centre mode did not turn");
  a_cmp_down_only: assert property (
    ctrl_q.alignment_select == tmc_pkg::TMC_ALIGN_DOWN && !dir_down |=> !o_compare_hit)
    else $error("compare flag while counting up in mode 1");
  a_reload_now: assert property (
    wr_reload && !ctrl_q.reload_buffer_enable |=> reload_act_q == $past(wdata_q[CW-1:0]))
    else $error("unbuffered reload not immediate");
  a_reload_held: assert property (
    ctrl_q.reload_buffer_enable && !update_ev |=> $stable(reload_act_q))
    else $error("buffered reload applied early");
  a_div_four: assert property (
    ctrl_q.sampling_clock_divide == 2'b10 && o_sample_tick
    ##1 ctrl_q.sampling_clock_divide == 2'b10 |-> !o_sample_tick)
    else $error("divide by four ticked too often");
  a_rsv_zero: assert property (
    ctrl_q.reserved == 6'h00)
    else $error("reserved control bits set");
  a_irq_level: assert property (
    |(stat_q & mask_q) |=> o_irq)
    else $error("interrupt not raised");

  c_oneshot: cover property (ctrl_q.one_shot_enable && update_ev);
  c_centre_both: cover property (ctrl_q.alignment_select == tmc_pkg::TMC_ALIGN_BOTH && cmp_hit);
  c_buffered_reload: cover property (ctrl_q.reload_buffer_enable && update_ev);
  c_irq: cover property (o_irq);
endmodule // tmc_mode_control

//--- tmc_params.svh
/*
 * Register offsets, field positions, reset values and widths for the timer mode control.
 * Assumes it is included by its bare name from the design module and the test bench.
 */
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

`define TMC_OFS_CTRL 8'h00
`define TMC_OFS_MASK 8'h0c
`define TMC_OFS_STAT 8'h10
`define TMC_OFS_EVGEN 8'h14
`define TMC_OFS_COUNT 8'h24
`define TMC_OFS_RELOAD 8'h2c
`define TMC_OFS_CMP 8'h34

`define TMC_CTRL_RESET 16'h0000
`define TMC_CTRL_WMASK 16'h03ff
`define TMC_RELOAD_RESET 16'hffff
`define TMC_BIT_RUN 0
`define TMC_BIT_DIR 4
`define TMC_BIT_SWUPD 0
`define TMC_ST_UPDATE 0
`define TMC_ST_COMPARE 1
`define TMC_ST_WIDTH 2
`define TMC_CNT_WIDTH 16

`endif

//--- tmc_pkg.sv
/*
 * Types shared by the timer mode control: the control register layout and its modes.
 * Assumes tmc_params.svh is reachable on the include path.
 */
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_ALIGN_EDGE = 2'b00,
    TMC_ALIGN_DOWN = 2'b01,
    TMC_ALIGN_UP = 2'b10,
    TMC_ALIGN_BOTH = 2'b11
  } tmc_align_e;

  typedef struct packed {
    logic [5:0] reserved;
    logic [1:0] sampling_clock_divide;
    logic reload_buffer_enable;
    tmc_align_e alignment_select;
    logic count_direction;
    logic one_shot_enable;
    logic update_request_source_sel;
    logic update_disable_bit;
    logic counter_run_enable;
  } tmc_ctrl_s;
endpackage

//--- test_tmc_mode_control.sv
/*
 * Self-checking bench for the timer mode control: register bus, update sources,
 * one-shot stop, direction lock, centre compare timing, reload buffering, divider.
 * Assumes the design's own assertions and the register map of tmc_params.svh.
 */
`timescale 1ns/1ps
`include "tmc_params.svh"

module test_tmc_mode_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slv = 1'b0;
  logic enc = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, upd, req, hit, tick, run;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0;
  int compares = 0;
  int ev_n = 0, req_n = 0, hit_n = 0, tk_n = 0, cyc = 0, last_ev = 0, gap = 0;

  always #12.5 clk = ~clk;

  tmc_mode_control dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_slave_update(slv),
    .i_encoder_mode(enc), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .o_irq(irq), .o_update_event(upd),
    .o_update_request(req), .o_compare_hit(hit), .o_sample_tick(tick), .o_counter_run(run));

  // Pulses are counted mid-cycle, where registered outputs have settled.
  always @(negedge clk) begin
    cyc++;
    if (upd === 1'b1) begin
      ev_n++;
      gap = cyc - last_ev;
      last_ev = cyc;
    end
    if (req === 1'b1) req_n++;
    if (hit === 1'b1) hit_n++;
    if (tick === 1'b1) tk_n++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic stall();
    err_count++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask

  // Ready is judged at the falling edge, so the rising edge that follows is the handshake.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic da, dw, ta, tw, bb;
    da = 0;
    dw = 0;
    bb = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !(da && dw); n++) begin
      @(negedge clk);
      ta = !da && awready;
      tw = !dw && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    for (n = 0; n < 40 && !bb; n++) begin
      @(negedge clk);
      bb = bvalid;
      r = bresp;
    end
    if (!bb) stall();
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !t; n++) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
      if (t) arvalid <= 1'b0;
    end
    t = 0;
    for (n = 0; n < 40 && !t; n++) begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      r = rresp;
    end
    if (!t) stall();
    @(posedge clk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_wr(a, d, r);
    check(r, 2'b00);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    bus_rd(a, d, r);
    check(r, 2'b00);
  endtask

  task automatic wait_ev();
    int e0, n;
    e0 = ev_n;
    for (n = 0; n < 200 && ev_n == e0; n++) @(posedge clk);
    if (ev_n == e0) stall();
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(`TMC_OFS_CTRL, d);
    check(d, 32'h0);
    rd(`TMC_OFS_RELOAD, d);
    check(d, 32'hffff);
    check(run, 1'b0);
    bus_rd(8'h40, d, r);
    check({r, d}, {2'b10, 32'h0});
    bus_wr(8'h40, 32'h1, r);
    check(r, 2'b10);
    wr(`TMC_OFS_CTRL, 32'hfc00);
    rd(`TMC_OFS_CTRL, d);
    check(d, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_source();
    logic [31:0] d;
    logic [15:0] ctl [3] = '{16'h0000, 16'h0004, 16'h0002};
    int e0, r0;
    wr(`TMC_OFS_MASK, 32'h1);
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 2; s++) begin
        wr(`TMC_OFS_CTRL, {16'h0, ctl[c]});
        wr(`TMC_OFS_STAT, 32'h3);
        e0 = ev_n;
        r0 = req_n;
        if (s == 1) begin
          @(posedge clk);
          slv <= 1'b1;
          @(posedge clk);
          slv <= 1'b0;
        end else wr(`TMC_OFS_EVGEN, 32'h1);
        repeat (4) @(posedge clk);
        check(ev_n - e0, c != 2);
        check(req_n - r0, c == 0);
        rd(`TMC_OFS_STAT, d);
        check(d & 32'h1, c == 0);
        check(irq, c == 0);
      end
    end
    wr(`TMC_OFS_STAT, 32'h3);
    wr(`TMC_OFS_MASK, 32'h0);
    wr(`TMC_OFS_CTRL, 32'h0);
    wr(`TMC_OFS_EVGEN, 32'h1);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    wr(`TMC_OFS_STAT, 32'h1);
    rd(`TMC_OFS_STAT, d);
    check(d & 32'h1, 32'h0);
    $display("test update sources done");
  endtask

  task automatic t_dir_div();
    logic [31:0] d;
    int t0;
    enc <= 1'b1;
    wr(`TMC_OFS_CTRL, 32'h10);
    rd(`TMC_OFS_CTRL, d);
    check(d & 32'h10, 32'h0);
    enc <= 1'b0;
    wr(`TMC_OFS_CTRL, 32'h10);
    rd(`TMC_OFS_CTRL, d);
    check(d & 32'h10, 32'h10);
    for (int dv = 0; dv < 4; dv++) begin
      wr(`TMC_OFS_CTRL, dv << 8);
      repeat (4) @(posedge clk);
      t0 = tk_n;
      repeat (16) @(posedge clk);
      check(tk_n - t0, 16 >> ((dv == 3) ? 2 : dv));
    end
    $display("test direction and divider done");
  endtask

  task automatic t_centre();
    int h0;
    for (int m = 1; m < 4; m++) begin
      // Direction is only writable in edge mode, so clear twice to leave centre mode first.
      wr(`TMC_OFS_CTRL, 32'h0);
      wr(`TMC_OFS_CTRL, 32'h0);
      wr(`TMC_OFS_COUNT, 32'h0);
      wr(`TMC_OFS_RELOAD, 32'h7);
      wr(`TMC_OFS_CMP, 32'h5);
      wr(`TMC_OFS_CTRL, m << 5);
      h0 = hit_n;
      wr(`TMC_OFS_CTRL, (m << 5) | 1);
      // The run passes the compare value three times counting up and twice counting down.
      repeat (32) @(posedge clk);
      wr(`TMC_OFS_CTRL, m << 5);
      repeat (3) @(posedge clk);
      check(hit_n - h0, (m == 1) ? 2 : ((m == 2) ? 3 : 5));
    end
    wr(`TMC_OFS_CTRL, 32'h0);
    wr(`TMC_OFS_CTRL, 32'h0);
    $display("test centre compare done");
  endtask

  task automatic t_reload();
    int r0;
    logic [31:0] d;
    for (int b = 0; b < 2; b++) begin
      wr(`TMC_OFS_CTRL, 32'h0);
      wr(`TMC_OFS_COUNT, 32'h0);
      wr(`TMC_OFS_RELOAD, 32'h9);
      wr(`TMC_OFS_CTRL, b ? 32'h85 : 32'h1);
      wait_ev();
      r0 = req_n;
      wait_ev();
      check(gap, 10);
      wr(`TMC_OFS_RELOAD, 32'd19);
      wait_ev();
      check(gap, b ? 10 : 20);
      wait_ev();
      check(gap, 20);
      check(req_n - r0, 3);
    end
    wr(`TMC_OFS_CTRL, 32'h0);
    wr(`TMC_OFS_RELOAD, 32'h9);
    wr(`TMC_OFS_COUNT, 32'h5);
    // One-shot while counting down: the underflow reloads the counter and stops it.
    wr(`TMC_OFS_CTRL, 32'h19);
    wait_ev();
    repeat (3) @(posedge clk);
    check(run, 1'b0);
    rd(`TMC_OFS_CTRL, d);
    check(d & 32'h1, 32'h0);
    r0 = ev_n;
    repeat (30) @(posedge clk);
    check(ev_n - r0, 0);
    rd(`TMC_OFS_COUNT, d);
    check(d, 32'h9);
    $display("test reload and one-shot done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_source();
    t_dir_div();
    t_centre();
    t_reload();
    print_verdict();
  end
endmodule // test_tmc_mode_control
